// >>> flbpe_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "flbpe_defs.svh"
// Function
// - Flash can be programmed one byte per operation from debug or CPU.
// - A byte program only clears bits, storing old AND written value.
// - An erase sets every byte of one 512-byte page to 0xFF.
// - Each program and erase is timed internally, no polling needed.
// - The CPU is stalled during an operation while peripherals run on.
// - Interrupts during an operation are held, then delivered afterwards.
// - Redirect bit one sends data writes to flash, zero to data RAM.
// - The redirect bit stays set until software clears it.
// - Data-space reads always go to data RAM.
// - Flash is read back through code-space reads.
// - Software program and erase happen only while the gate bit is one.
// - A redirected write with erase-arm set erases the containing page.
// - A blank device is programmable only through the debug port.
module flbpe_top #(
  parameter int unsigned WRITE_CYC = `FLBPE_WRITE_CYC,
  parameter int unsigned ERASE_CYC = `FLBPE_ERASE_CYC,
  parameter int          CNT_W     = `FLBPE_CNT_W,
  parameter int          ADDR_W    = `FLBPE_ADDR_W,
  parameter int          PAGE_W    = `FLBPE_PAGE_W,
  parameter int          IRQ_N     = `FLBPE_IRQ_N
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              cpu_xwr,
  input  wire logic              cpu_xrd,
  input  wire logic [ADDR_W-1:0] cpu_addr,
  input  wire logic [7:0]        cpu_wdata,
  input  wire logic              cpu_code_rd,
  input  wire logic [ADDR_W-1:0] cpu_code_addr,
  output logic [7:0]             code_rdata,
  output logic                   cpu_stall,
  output logic                   data_ram_space_we,
  output logic [ADDR_W-1:0]      data_ram_space_addr,
  output logic [7:0]             data_ram_space_wdata,
  output logic                   data_ram_space_re,
  input  wire logic [7:0]        sfr_wdata,
  input  wire logic              store_ctl_we,
  input  wire logic              scale_we,
  output logic [7:0]             store_control_reg,
  output logic [7:0]             flash_scale_reg,
  input  wire logic              code_present,
  input  wire logic              dbg_req,
  input  wire logic              dbg_erase,
  input  wire logic [ADDR_W-1:0] dbg_addr,
  input  wire logic [7:0]        dbg_wdata,
  output logic                   dbg_ready,
  output logic                   dbg_done,
  input  wire logic [IRQ_N-1:0]  irq_in,
  output logic [IRQ_N-1:0]       irq_out,
  output logic                   flash_wr_refused,
  output flbpe_pkg::flbpe_op_t   op_kind
);
  import flbpe_pkg::*;

  // Decide where a data-space write lands
  function automatic logic flash_wr_ok(input logic       wr,
                                       input logic [7:0] ctl,
                                       input logic [7:0] scl,
                                       input logic       present);
    flash_wr_ok = wr && ctl[`FLBPE_REDIRECT_BIT] &&
                  scl[`FLBPE_GATE_BIT] && present;
  endfunction

  flbpe_state_t      st_r;
  flbpe_state_t      st_nxt;
  flbpe_op_t         op_r;
  flbpe_op_t         op_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  logic [7:0]        data_r;
  logic [7:0]        data_nxt;
  logic              from_dbg_r;
  logic              from_dbg_nxt;
  logic [7:0]        ctl_r;
  logic [7:0]        ctl_nxt;
  logic [7:0]        scl_r;
  logic [7:0]        scl_nxt;
  logic              xwe_r;
  logic              xwe_nxt;
  logic [ADDR_W-1:0] xaddr_r;
  logic [ADDR_W-1:0] xaddr_nxt;
  logic [7:0]        xdata_r;
  logic [7:0]        xdata_nxt;
  logic              refused_r;
  logic              refused_nxt;
  logic [IRQ_N-1:0]  pend_r;
  logic [IRQ_N-1:0]  pend_nxt;
  logic              cpu_flash_req;
  logic              dbg_take;
  logic              launch;
  logic              tmr_busy;
  logic              tmr_done;
  logic [CNT_W-1:0]  tmr_load_val;

  // ============================================================
  // Control registers written by the CPU side
  always_comb begin
    ctl_nxt = ctl_r;
    scl_nxt = scl_r;
    // only a software write changes the redirect bit
    if (store_ctl_we) begin
      ctl_nxt = sfr_wdata;
    end
    if (scale_we) begin
      scl_nxt = sfr_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_r <= `FLBPE_STORE_CTL_RST;
      scl_r <= `FLBPE_SCALE_RST;
    end else begin
      ctl_r <= ctl_nxt;
      scl_r <= scl_nxt;
    end
  end

  assign store_control_reg = ctl_r;
  assign flash_scale_reg   = scl_r;

  // ============================================================
  // Request decode
  // software path needs the gate bit
  // a blank device takes no self-programming
  assign cpu_flash_req = (st_r == FLBPE_IDLE) &&
                         flash_wr_ok(cpu_xwr, ctl_r, scl_r, code_present);
  // CPU wins a tie; debug waits until the CPU operation has finished
  assign dbg_ready = (st_r == FLBPE_IDLE) && !cpu_flash_req;
  // debug port programs without the software gate
  assign dbg_take  = dbg_req && dbg_ready;
  assign launch    = (st_r == FLBPE_LAUNCH);

  // ============================================================
  // Sequencer
  always_comb begin
    st_nxt       = st_r;
    op_nxt       = op_r;
    addr_nxt     = addr_r;
    data_nxt     = data_r;
    from_dbg_nxt = from_dbg_r;
    unique case (st_r)
      FLBPE_IDLE: begin
        if (cpu_flash_req) begin
          // erase-arm turns the write into a page erase
          op_nxt       = ctl_r[`FLBPE_ERASE_ARM_BIT] ? FLBPE_OP_ERASE
                                                     : FLBPE_OP_PROG;
          addr_nxt     = cpu_addr;
          data_nxt     = cpu_wdata;
          from_dbg_nxt = 1'b0;
          st_nxt       = FLBPE_LAUNCH;
        end else if (dbg_take) begin
          op_nxt       = dbg_erase ? FLBPE_OP_ERASE : FLBPE_OP_PROG;
          addr_nxt     = dbg_addr;
          data_nxt     = dbg_wdata;
          from_dbg_nxt = 1'b1;
          st_nxt       = FLBPE_LAUNCH;
        end
      end
      FLBPE_LAUNCH: begin
        st_nxt = FLBPE_BUSY;
      end
      FLBPE_BUSY: begin
        // hardware ends the operation by itself
        if (tmr_done) begin
          st_nxt = FLBPE_IDLE;
        end
      end
      default: begin
        st_nxt = FLBPE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r       <= FLBPE_IDLE;
      op_r       <= FLBPE_OP_PROG;
      addr_r     <= '0;
      data_r     <= 8'h00;
      from_dbg_r <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      op_r       <= op_nxt;
      addr_r     <= addr_nxt;
      data_r     <= data_nxt;
      from_dbg_r <= from_dbg_nxt;
    end
  end

  // CPU halts for the whole operation, peripherals untouched
  assign cpu_stall = (st_r != FLBPE_IDLE);
  assign dbg_done  = from_dbg_r && (st_r == FLBPE_BUSY) && tmr_done;
  assign op_kind   = op_r;

  assign tmr_load_val = (op_r == FLBPE_OP_ERASE) ? CNT_W'(ERASE_CYC)
                                                 : CNT_W'(WRITE_CYC);

  flbpe_timer #(
    .CNT_W (CNT_W)
  ) u_timer (
    .clk      (clk),
    .rst      (rst),
    .load     (launch),
    .load_val (tmr_load_val),
    .busy     (tmr_busy),
    .done     (tmr_done)
  );

  flbpe_array #(
    .ADDR_W (ADDR_W),
    .PAGE_W (PAGE_W)
  ) u_array (
    .clk          (clk),
    .rst          (rst),
    .op_start     (launch),
    .op_kind      (op_r),
    .op_addr      (addr_r),
    .op_data      (data_r),
    .code_rd      (cpu_code_rd),
    .code_addr    (cpu_code_addr),
    .code_rdata   (code_rdata),
    .erase_active ()
  );

  // ============================================================
  // Data RAM path and refusals
  always_comb begin
    // redirect clear sends writes to data RAM
    xwe_nxt     = cpu_xwr && !ctl_r[`FLBPE_REDIRECT_BIT] && !cpu_stall;
    xaddr_nxt   = xwe_nxt ? cpu_addr : xaddr_r;
    xdata_nxt   = xwe_nxt ? cpu_wdata : xdata_r;
    // Redirected write that the gate blocks lands nowhere
    refused_nxt = cpu_xwr && ctl_r[`FLBPE_REDIRECT_BIT] && !cpu_stall &&
                  !flash_wr_ok(cpu_xwr, ctl_r, scl_r, code_present);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xwe_r     <= 1'b0;
      xaddr_r   <= '0;
      xdata_r   <= 8'h00;
      refused_r <= 1'b0;
    end else begin
      xwe_r     <= xwe_nxt;
      xaddr_r   <= xaddr_nxt;
      xdata_r   <= xdata_nxt;
      refused_r <= refused_nxt;
    end
  end

  assign data_ram_space_we          = xwe_r;
  assign data_ram_space_addr        = xaddr_r;
  assign data_ram_space_wdata       = xdata_r;
  assign flash_wr_refused = refused_r;
  assign data_ram_space_re          = cpu_xrd && !cpu_stall;

  // ============================================================
  // Interrupt hold
  // requests collected while stalled, released after
  always_comb begin
    pend_nxt = cpu_stall ? (pend_r | irq_in) : '0;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_r <= '0;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  assign irq_out = cpu_stall ? '0 : (pend_r | irq_in);

  // ============================================================
  // Checks
  int unsigned stall_len_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stall_len_r <= 0;
    end else if (cpu_stall) begin
      stall_len_r <= stall_len_r + 1;
    end else begin
      stall_len_r <= 0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  stall_on_op_a: assert property (
    cpu_flash_req || dbg_take |=> cpu_stall [*2])
    else $error("CPU not stalled after flash operation start");
  op_length_a: assert property (
    $fell(cpu_stall) |-> stall_len_r ==
      ((op_r == FLBPE_OP_ERASE) ? ERASE_CYC : WRITE_CYC) + 1)
    else $error("busy interval differs from programmed duration");
  redirect_hold_a: assert property (
    ctl_r[`FLBPE_REDIRECT_BIT] && !store_ctl_we |=>
      ctl_r[`FLBPE_REDIRECT_BIT])
    else $error("redirect bit cleared without software write");
  data_ram_space_route_a: assert property (
    cpu_xwr && !cpu_stall && !ctl_r[`FLBPE_REDIRECT_BIT] |=>
      data_ram_space_we && data_ram_space_addr == $past(cpu_addr) && st_r == FLBPE_IDLE)
    else $error("plain data write did not reach data RAM");
  data_ram_space_read_a: assert property (
    cpu_xrd && !cpu_stall && ctl_r[`FLBPE_REDIRECT_BIT] |-> data_ram_space_re)
    else $error("data read diverted by redirect bit");
  gate_block_a: assert property (
    cpu_xwr && !scl_r[`FLBPE_GATE_BIT] && !dbg_req |=>
      st_r != FLBPE_LAUNCH)
    else $error("flash operation started with gate closed");
  erase_select_a: assert property (
    cpu_flash_req && ctl_r[`FLBPE_ERASE_ARM_BIT] |=>
      op_r == FLBPE_OP_ERASE && launch)
    else $error("armed redirected write did not erase");
  irq_mask_a: assert property (
    cpu_stall |-> irq_out == '0)
    else $error("interrupt delivered during flash operation");
  irq_release_a: assert property (
    $fell(cpu_stall) && $past(pend_r[0] || irq_in[0]) |-> irq_out[0])
    else $error("held interrupt lost after flash operation");
  blank_block_a: assert property (
    !code_present && !dbg_req |=> st_r != FLBPE_LAUNCH)
    else $error("blank device self-programmed");
  busy_match_a: assert property (
    st_r == FLBPE_BUSY |-> tmr_busy)
    else $error("sequencer busy while timer idle");
  prog_done_c: cover property (
    launch && op_r == FLBPE_OP_PROG ##[1:300] $fell(cpu_stall));
  erase_start_c: cover property (cpu_flash_req &&
    ctl_r[`FLBPE_ERASE_ARM_BIT]);
  irq_held_c: cover property (cpu_stall && irq_in != '0);
  dbg_done_c: cover property (dbg_done);
endmodule
`default_nettype wire

// >>> flbpe_defs.svh
`ifndef FLBPE_DEFS_SVH
`define FLBPE_DEFS_SVH

// ============================================================
// Control register fields and reset values
`define FLBPE_REDIRECT_BIT   0
`define FLBPE_ERASE_ARM_BIT  1
`define FLBPE_GATE_BIT       0
`define FLBPE_STORE_CTL_RST  8'h00
`define FLBPE_SCALE_RST      8'h00

// ============================================================
// Array geometry
`define FLBPE_ADDR_W         16
`define FLBPE_PAGE_W         9
`define FLBPE_PAGE_BYTES     512
`define FLBPE_ERASED_BYTE    8'hFF
`define FLBPE_RESERVED_BASE  16'hFE00

// ============================================================
// Timing: nanoseconds as printed, cycles derived (rounded up)
`define FLBPE_CLK_NS         20
`define FLBPE_WRITE_NS       50000
`define FLBPE_ERASE_NS       12000000
`define FLBPE_WRITE_CYC \
  ((`FLBPE_WRITE_NS + `FLBPE_CLK_NS - 1) / `FLBPE_CLK_NS)
`define FLBPE_ERASE_CYC \
  ((`FLBPE_ERASE_NS + `FLBPE_CLK_NS - 1) / `FLBPE_CLK_NS)
`define FLBPE_CNT_W          20
`define FLBPE_IRQ_N          8

`endif

// >>> flbpe_pkg.sv
package flbpe_pkg;

  // ============================================================
  // Sequencer states, Gray along idle, launch, busy
  typedef enum logic [1:0] {
    FLBPE_IDLE   = 2'h0,
    FLBPE_LAUNCH = 2'h1,
    FLBPE_BUSY   = 2'h3
  } flbpe_state_t;

  typedef enum logic {
    FLBPE_OP_PROG  = 1'h0,
    FLBPE_OP_ERASE = 1'h1
  } flbpe_op_t;

endpackage

// >>> flbpe_timer.sv
`timescale 1ns/1ns
`default_nettype none
module flbpe_timer #(
  parameter int CNT_W = 20
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] load_val,
  output logic                  busy,
  output logic                  done
);
  import flbpe_pkg::*;

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             busy_r;
  logic             busy_nxt;

  // ============================================================
  // Down counter
  // counted busy interval
  always_comb begin
    cnt_nxt  = cnt_r;
    busy_nxt = busy_r;
    if (load) begin
      cnt_nxt  = load_val;
      busy_nxt = 1'b1;
    end else if (busy_r) begin
      cnt_nxt = cnt_r - CNT_W'(1);
      if (cnt_r == CNT_W'(1)) begin
        busy_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign busy = busy_r;
  assign done = busy_r && (cnt_r == CNT_W'(1));

  // ============================================================
  // Checks
  timer_expiry_a: assert property (@(posedge clk) disable iff (rst)
    done && !load |=> !busy)
    else $error("timer stayed busy after expiry");
endmodule
`default_nettype wire

// >>> flbpe_array.sv
`timescale 1ns/1ns
`default_nettype none
`include "flbpe_defs.svh"
module flbpe_array #(
  parameter int ADDR_W = `FLBPE_ADDR_W,
  parameter int PAGE_W = `FLBPE_PAGE_W
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                op_start,
  input  wire flbpe_pkg::flbpe_op_t op_kind,
  input  wire logic [ADDR_W-1:0]   op_addr,
  input  wire logic [7:0]          op_data,
  input  wire logic                code_rd,
  input  wire logic [ADDR_W-1:0]   code_addr,
  output logic [7:0]               code_rdata,
  output logic                     erase_active
);
  import flbpe_pkg::*;

  // Non-volatile contents: no reset on the array itself
  logic [7:0]               mem [0:(2**ADDR_W)-1];
  logic                     er_act_r;
  logic                     er_act_nxt;
  logic [ADDR_W-PAGE_W-1:0] er_page_r;
  logic [ADDR_W-PAGE_W-1:0] er_page_nxt;
  logic [PAGE_W-1:0]        er_idx_r;
  logic [PAGE_W-1:0]        er_idx_nxt;
  logic [7:0]               rd_r;
  logic [7:0]               rd_nxt;
  logic                     wr_en;
  logic [ADDR_W-1:0]        wr_addr;
  logic [7:0]               wr_data;

  // ============================================================
  // Array write port: byte program or page walk
  always_comb begin
    er_act_nxt  = er_act_r;
    er_page_nxt = er_page_r;
    er_idx_nxt  = er_idx_r;
    wr_en       = 1'b0;
    wr_addr     = op_addr;
    wr_data     = op_data;
    if (er_act_r) begin
      // every byte of the page to erased value
      wr_en      = 1'b1;
      wr_addr    = {er_page_r, er_idx_r};
      wr_data    = `FLBPE_ERASED_BYTE;
      er_idx_nxt = er_idx_r + PAGE_W'(1);
      if (&er_idx_r) begin
        er_act_nxt = 1'b0;
      end
    end else if (op_start && op_kind == FLBPE_OP_ERASE) begin
      er_act_nxt  = 1'b1;
      er_page_nxt = op_addr[ADDR_W-1:PAGE_W];
      er_idx_nxt  = '0;
    end else if (op_start) begin
      wr_en   = 1'b1;
      wr_data = mem[op_addr] & op_data;
    end
  end

  // flash contents return on code reads
  always_comb begin
    rd_nxt = rd_r;
    if (code_rd) begin
      rd_nxt = mem[code_addr];
    end
  end

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      er_act_r  <= 1'b0;
      er_page_r <= '0;
      er_idx_r  <= '0;
      rd_r      <= 8'h00;
    end else begin
      er_act_r  <= er_act_nxt;
      er_page_r <= er_page_nxt;
      er_idx_r  <= er_idx_nxt;
      rd_r      <= rd_nxt;
    end
  end

  assign code_rdata   = rd_r;
  assign erase_active = er_act_r;

  // ============================================================
  // Checks
  // stored byte is old AND new
  prog_and_a: assert property (@(posedge clk) disable iff (rst)
    op_start && op_kind == FLBPE_OP_PROG && !er_act_r |=>
      mem[$past(op_addr)] == ($past(mem[op_addr]) & $past(op_data)))
    else $error("byte program did not AND into old contents");
  // erase walk ends after whole page
  erase_walk_a: assert property (@(posedge clk) disable iff (rst)
    er_act_r && (&er_idx_r) |=> !er_act_r &&
      mem[$past(wr_addr)] == `FLBPE_ERASED_BYTE)
    else $error("page erase walk did not finish cleanly");
endmodule
`default_nettype wire

// >>> flbpe_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module flbpe_cpu_model (
  input  wire logic        clk,
  input  wire logic        cpu_stall,
  input  wire logic        data_ram_space_re,
  input  wire logic [7:0]  code_rdata,
  output logic             cpu_xwr,
  output logic             cpu_xrd,
  output logic [15:0]      cpu_addr,
  output logic [7:0]       cpu_wdata,
  output logic             cpu_code_rd,
  output logic [15:0]      cpu_code_addr
);
  initial begin
    cpu_xwr = 1'b0;
    cpu_xrd = 1'b0;
    cpu_code_rd = 1'b0;
    cpu_addr = 16'h0000;
    cpu_wdata = 8'h00;
    cpu_code_addr = 16'h0000;
  end

  // ============================================================
  // Access tasks, called at a falling edge
  // a stalled core issues nothing
  task automatic wait_free();
    int i;
    for (i = 0; i < 2000 && cpu_stall !== 1'b0; i++) @(negedge clk);
  endtask

  // Released lines show the inverse so stale values cannot pass
  task automatic xwr(input logic [15:0] a, input logic [7:0] d);
    wait_free();
    cpu_xwr = 1'b1;
    cpu_addr = a;
    cpu_wdata = d;
    @(negedge clk);
    cpu_xwr = 1'b0;
    cpu_addr = ~a;
    cpu_wdata = ~d;
  endtask

  task automatic xrd(input logic [15:0] a, output logic seen);
    wait_free();
    cpu_xrd = 1'b1;
    cpu_addr = a;
    #1;
    seen = data_ram_space_re;
    @(negedge clk);
    cpu_xrd = 1'b0;
    cpu_addr = ~a;
  endtask

  // flash is read through code-space reads
  task automatic code_rd(input logic [15:0] a, output logic [7:0] d);
    wait_free();
    cpu_code_rd = 1'b1;
    cpu_code_addr = a;
    @(negedge clk);
    cpu_code_rd = 1'b0;
    cpu_code_addr = ~a;
    d = code_rdata;
    // Gap cycle so a following read never retoggles the strobe at once
    @(negedge clk);
  endtask
endmodule
`default_nettype wire

// >>> flbpe_tb.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import flbpe_pkg::*;
  localparam int WCYC = 4;
  localparam int ECYC = 520;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  sfr_wdata = 8'h00;
  logic        store_ctl_we = 1'b0;
  logic        scale_we = 1'b0;
  logic        code_present = 1'b1;
  logic        dbg_req = 1'b0;
  logic        dbg_erase = 1'b0;
  logic [15:0] dbg_addr = 16'h0000;
  logic [7:0]  dbg_wdata = 8'h00;
  logic [7:0]  irq_in = 8'h00;
  logic        cpu_xwr, cpu_xrd, cpu_code_rd;
  logic [15:0] cpu_addr, cpu_code_addr, data_ram_space_addr;
  logic [7:0]  cpu_wdata, code_rdata, data_ram_space_wdata, irq_out;
  logic        cpu_stall, data_ram_space_we, data_ram_space_re, dbg_ready, dbg_done;
  logic        flash_wr_refused;
  logic [7:0]  store_control_reg, flash_scale_reg;
  flbpe_op_t   op_kind;
  int          errors = 0;
  int          checked = 0;

  always #10 clk = ~clk;

  flbpe_top #(.WRITE_CYC(WCYC), .ERASE_CYC(ECYC)) dut (
    .clk(clk), .rst(rst), .cpu_xwr(cpu_xwr), .cpu_xrd(cpu_xrd),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_code_rd(cpu_code_rd), .cpu_code_addr(cpu_code_addr),
    .code_rdata(code_rdata), .cpu_stall(cpu_stall), .data_ram_space_we(data_ram_space_we),
    .data_ram_space_addr(data_ram_space_addr), .data_ram_space_wdata(data_ram_space_wdata), .data_ram_space_re(data_ram_space_re),
    .sfr_wdata(sfr_wdata), .store_ctl_we(store_ctl_we),
    .scale_we(scale_we), .store_control_reg(store_control_reg),
    .flash_scale_reg(flash_scale_reg), .code_present(code_present),
    .dbg_req(dbg_req), .dbg_erase(dbg_erase), .dbg_addr(dbg_addr),
    .dbg_wdata(dbg_wdata), .dbg_ready(dbg_ready), .dbg_done(dbg_done),
    .irq_in(irq_in), .irq_out(irq_out),
    .flash_wr_refused(flash_wr_refused), .op_kind(op_kind));

  flbpe_cpu_model cpu (
    .clk(clk), .cpu_stall(cpu_stall), .data_ram_space_re(data_ram_space_re),
    .code_rdata(code_rdata), .cpu_xwr(cpu_xwr), .cpu_xrd(cpu_xrd),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_code_rd(cpu_code_rd), .cpu_code_addr(cpu_code_addr));

  // ============================================================
  // Compare and report
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_cnt(input int g, input int e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic summarize();
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ============================================================
  // Helpers
  task automatic set_ctl(input logic [7:0] s, input logic [7:0] g);
    sfr_wdata = s;
    store_ctl_we = 1'b1;
    @(negedge clk);
    store_ctl_we = 1'b0;
    sfr_wdata = g;
    scale_we = 1'b1;
    @(negedge clk);
    scale_we = 1'b0;
    sfr_wdata = ~g;
  endtask

  // Counts stall cycles; an irq pulse lands inside the stall
  // core has interrupts masked, requests still arrive and are held
  task automatic op_check(input int exp, input logic [7:0] irq);
    int n;
    int i;
    n = 0;
    for (i = 0; i < 4 && cpu_stall !== 1'b1; i++) @(negedge clk);
    irq_in = irq;
    while (cpu_stall === 1'b1 && n < 2000) begin
      n++;
      @(negedge clk);
      irq_in = 8'h00;
      if (cpu_stall === 1'b1) chk8(irq_out, 8'h00);
    end
    chk_cnt(n, exp);
    chk8(irq_out, irq);
  endtask

  task automatic rd_check(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    cpu.code_rd(a, d);
    chk8(d, e);
  endtask

  // ============================================================
  // Scenarios
  task automatic t_reset();
    chk8(store_control_reg, 8'h00);
    chk8(flash_scale_reg, 8'h00);
    chk1(cpu_stall, 1'b0);
    chk1(dbg_ready, 1'b1);
  endtask

  task automatic t_ram();
    set_ctl(8'h00, 8'h01);
    cpu.xwr(16'h0123, 8'h5A);
    chk1(data_ram_space_we, 1'b1);
    chk8(data_ram_space_addr[7:0], 8'h23);
    chk8(data_ram_space_addr[15:8], 8'h01);
    chk8(data_ram_space_wdata, 8'h5A);
    chk1(cpu_stall, 1'b0);
  endtask

  // test pages stay clear of the reserved top page
  task automatic t_erase();
    set_ctl(8'h03, 8'h01);
    cpu.xwr(16'h0234, 8'h00);
    op_check(ECYC + 1, 8'h00);
    chk1(op_kind, FLBPE_OP_ERASE);
    rd_check(16'h0200, 8'hFF);
    rd_check(16'h03FF, 8'hFF);
    rd_check(16'h0234, 8'hFF);
    chk8(store_control_reg, 8'h03);
  endtask

  task automatic t_prog();
    logic seen;
    set_ctl(8'h01, 8'h01);
    cpu.xwr(16'h0210, 8'hA5);
    op_check(WCYC + 1, 8'h05);
    rd_check(16'h0210, 8'hA5);
    cpu.xwr(16'h0210, 8'h3C);
    op_check(WCYC + 1, 8'h00);
    rd_check(16'h0210, 8'h24);
    rd_check(16'h0211, 8'hFF);
    chk8(store_control_reg, 8'h01);
    cpu.xrd(16'h0210, seen);
    chk1(seen, 1'b1);
  endtask

  task automatic t_refuse();
    set_ctl(8'h01, 8'h00);
    cpu.xwr(16'h0211, 8'h00);
    chk1(flash_wr_refused, 1'b1);
    chk1(data_ram_space_we, 1'b0);
    chk1(cpu_stall, 1'b0);
    set_ctl(8'h01, 8'h01);
    code_present = 1'b0;
    cpu.xwr(16'h0211, 8'h00);
    chk1(flash_wr_refused, 1'b1);
    chk1(cpu_stall, 1'b0);
    rd_check(16'h0211, 8'hFF);
  endtask

  // One debug operation, held until taken, then waited out
  task automatic dbg_op(input logic [15:0] a, input logic [7:0] d,
                        input logic e);
    int i;
    dbg_addr = a;
    dbg_wdata = d;
    dbg_erase = e;
    dbg_req = 1'b1;
    for (i = 0; i < 4 && dbg_ready !== 1'b1; i++) @(negedge clk);
    @(negedge clk);
    dbg_req = 1'b0;
    dbg_addr = ~a;
    dbg_wdata = ~d;
    dbg_erase = ~e;
    for (i = 0; i < 600 && dbg_done !== 1'b1; i++) @(negedge clk);
    chk1(dbg_done, 1'b1);
    @(negedge clk);
    chk1(cpu_stall, 1'b0);
  endtask

  // Blank device: only the debug port programs
  task automatic t_debug();
    dbg_op(16'h0211, 8'h0F, 1'b0);
    rd_check(16'h0211, 8'h0F);
    dbg_op(16'h0456, 8'h00, 1'b1);
    chk1(op_kind, FLBPE_OP_ERASE);
    rd_check(16'h0400, 8'hFF);
    rd_check(16'h05FF, 8'hFF);
    code_present = 1'b1;
  endtask

  // ============================================================
  // Main sequence and watchdog
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_reset();
    t_ram();
    t_erase();
    t_prog();
    t_refuse();
    t_debug();
    summarize();
  end

  // About 1100 cycles expected; generous margin
  initial begin
    #200000;
    errors++;
    summarize();
  end
endmodule
`default_nettype wire
